// ==== hw/cpt_tone_out.sv ====
// Call-progress tone output: AHB-Lite registers, path scaling, pin modulator.
// Assumes voice samples arrive on the system clock with a valid strobe.
// Contract
// RULE1: Software enables the tone by clearing the interrupt output enable, setting tone enable and format 00.
// RULE2: Receive and transmit contributions are each scaled linearly by their own attenuation register.
// RULE3: An all-zero attenuation value fully mutes its path in the monitor output.
// RULE4: Attenuation alters only the monitor output, never the line voice data.
// RULE5: A two-bit format field at bits 5:4 of the control register picks one of three waveforms.
// RULE6: Waveforms are a delta-sigma stream, a 32 kHz return-to-zero pulse and a balanced 32 kHz pulse.
// RULE7: Format 00 is delta-sigma, 01 return-to-zero, 10 balanced, and 11 drives the pin low.
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
module cpt_tone_out (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire cpt_pkg::cpt_voice_s i_voice,
  input wire logic i_voice_valid,
  output cpt_pkg::cpt_voice_s o_line_voice,
  output logic o_line_valid,
  output logic o_tone_output_pin
);

  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] rx_att;
    logic [7:0] tx_att;
    logic [1:0] fmt;
    logic tone_output_enable;
    logic irq_output_enable;
    cpt_pkg::cpt_voice_s voice;
    cpt_pkg::cpt_voice_s line_voice;
    logic line_valid;
    logic signed [15:0] level;
    logic [31:0] hrdata;
    logic ready;
    logic hresp;
  } cpt_top_state_s;

  cpt_top_state_s s_reg;
  cpt_top_state_s s_next;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic take;
  logic addr_ok;
  logic [7:0] a_idx;
  logic signed [23:0] rx_scaled;
  logic signed [23:0] tx_scaled;
  logic signed [24:0] mix_sum;
  logic signed [16:0] mix_shift;
  logic mod_enable;

  // Reset release through two flip-flops
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Address phase decode; only word-aligned addresses map, whatever the transfer size
  assign take = i_hsel && i_htrans[1] && i_hready;
  assign addr_ok = (i_haddr[31:10] == 22'h000000) && (i_haddr[1:0] == 2'b00);
  assign a_idx = addr_ok ? i_haddr[9:2] : 8'hff;

  function automatic logic [31:0] read_word(input cpt_top_state_s st, input logic [7:0] idx, input logic pin);
    logic [31:0] w;
    w = 32'h00000000;
    unique case (idx)
      cpt_pkg::CPT_IDX_CTRL1: begin
        w[cpt_pkg::CPT_FMT_LSB +: 2] = st.fmt;
        w[cpt_pkg::CPT_TONE_EN_BIT] = st.tone_output_enable;
      end
      cpt_pkg::CPT_IDX_CTRL2: w[cpt_pkg::CPT_IRQ_EN_BIT] = st.irq_output_enable;
      cpt_pkg::CPT_IDX_RX_ATT: w[7:0] = st.rx_att;
      cpt_pkg::CPT_IDX_TX_ATT: w[7:0] = st.tx_att;
      cpt_pkg::CPT_IDX_STATUS: begin
        w[cpt_pkg::CPT_ST_PIN_BIT] = pin;
        w[cpt_pkg::CPT_ST_ACTIVE_BIT] = st.tone_output_enable && !st.irq_output_enable
          && (st.fmt != cpt_pkg::CPT_FMT_RSVD);
        w[cpt_pkg::CPT_ST_LEVEL_LSB +: 16] = st.level;
      end
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction

  // Mix of the two scaled paths, saturated to 16 bits
  assign mix_sum = 25'(rx_scaled) + 25'(tx_scaled);
  assign mix_shift = 17'(mix_sum >>> cpt_pkg::CPT_ATT_SHIFT);

  always_comb begin
    s_next = s_reg;
    s_next.ready = 1'b1;
    s_next.hresp = 1'b0;
    // Data phase write lands before the next read is sampled
    if (s_reg.wr_pend) begin
      unique case (s_reg.wr_idx)
        cpt_pkg::CPT_IDX_CTRL1: begin
          s_next.fmt = i_hwdata[cpt_pkg::CPT_FMT_LSB +: 2]; // RULE5
          s_next.tone_output_enable = i_hwdata[cpt_pkg::CPT_TONE_EN_BIT]; // RULE1
        end
        cpt_pkg::CPT_IDX_CTRL2: s_next.irq_output_enable = i_hwdata[cpt_pkg::CPT_IRQ_EN_BIT]; // RULE1
        cpt_pkg::CPT_IDX_RX_ATT: s_next.rx_att = i_hwdata[7:0]; // RULE2
        cpt_pkg::CPT_IDX_TX_ATT: s_next.tx_att = i_hwdata[7:0]; // RULE2
        default: s_next.fmt = s_reg.fmt;
      endcase
    end
    s_next.wr_pend = take && i_hwrite;
    s_next.wr_idx = a_idx;
    if (take && !i_hwrite) begin
      s_next.hrdata = read_word(s_next, a_idx, o_tone_output_pin);
    end
    // Line data bypasses the attenuators entirely
    if (i_voice_valid) begin
      s_next.voice = i_voice;
      s_next.line_voice = i_voice; // RULE4
    end
    s_next.line_valid = i_voice_valid; // RULE4
    if (mix_shift > 17'sh07fff) begin
      s_next.level = 16'sh7fff;
    end else if (mix_shift < -17'sh08000) begin
      s_next.level = -16'sh8000;
    end else begin
      s_next.level = mix_shift[15:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.rx_att <= cpt_pkg::CPT_ATT_RST;
      s_reg.tx_att <= cpt_pkg::CPT_ATT_RST;
      s_reg.fmt <= cpt_pkg::CPT_FMT_RST;
      s_reg.tone_output_enable <= cpt_pkg::CPT_TONE_EN_RST;
      s_reg.irq_output_enable <= cpt_pkg::CPT_IRQ_EN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  cpt_path_scaler u_rx_scaler (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_sample(s_reg.voice.rx),
    .i_atten(s_reg.rx_att),
    .o_scaled(rx_scaled)
  );

  cpt_path_scaler u_tx_scaler (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_sample(s_reg.voice.tx),
    .i_atten(s_reg.tx_att),
    .o_scaled(tx_scaled)
  );

  // Pin free for interrupt use unless that use is off
  assign mod_enable = s_reg.tone_output_enable && !s_reg.irq_output_enable; // RULE1

  cpt_tone_mod u_mod (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_level(s_reg.level),
    .i_format(cpt_pkg::cpt_fmt_e'(s_reg.fmt)),
    .i_enable(mod_enable),
    .o_pin(o_tone_output_pin)
  );

  assign o_hrdata = s_reg.hrdata;
  assign o_hreadyout = s_reg.ready;
  assign o_hresp = s_reg.hresp;
  assign o_line_voice = s_reg.line_voice;
  assign o_line_valid = s_reg.line_valid;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  chk_line_untouched: assert property ( // RULE4
    i_voice_valid |=> (o_line_valid && o_line_voice == $past(i_voice)))
    else $error("line voice altered or lost");

  chk_format_write: assert property ( // RULE5
    (s_reg.wr_pend && s_reg.wr_idx == cpt_pkg::CPT_IDX_CTRL1)
      |=> (s_reg.fmt == $past(i_hwdata[cpt_pkg::CPT_FMT_LSB +: 2])))
    else $error("format field not taken from bits 5:4");

  chk_mute_both: assert property ( // RULE3
    (s_reg.rx_att == 8'h00 && s_reg.tx_att == 8'h00) [*3] |=> (s_reg.level == 16'sh0000))
    else $error("muted paths still reach the monitor level");

  chk_pin_gated: assert property ( // RULE1
    (!mod_enable) [*2] |-> !o_tone_output_pin)
    else $error("tone pin active while output disabled");

  cov_dsig_on: cover property (mod_enable && s_reg.fmt == cpt_pkg::CPT_FMT_DSIG ##1 o_tone_output_pin);
  cov_att_write: cover property (s_reg.wr_pend && s_reg.wr_idx == cpt_pkg::CPT_IDX_RX_ATT);
  cov_read: cover property (take && !i_hwrite ##1 o_hrdata != 32'h00000000);

endmodule // cpt_tone_out

// ==== hw/cpt_pkg.sv ====
// Shared constants and types of the call-progress tone output block.
// Assumes a single 100 MHz system clock and an AHB-Lite register bus.
package cpt_pkg;

  // Clock and tone timing
  localparam int CPT_CLK_HZ = 100_000_000;
  localparam int CPT_TONE_HZ = 32_000;
  // Exact division: 3125 cycles per tone period
  localparam int CPT_PERIOD_CYC = CPT_CLK_HZ / CPT_TONE_HZ;
  localparam logic [11:0] CPT_PERIOD_W = 12'(CPT_PERIOD_CYC);
  localparam logic [11:0] CPT_CNT_LAST = 12'(CPT_PERIOD_CYC - 1);
  localparam logic [11:0] CPT_CNT_HALF = 12'(CPT_PERIOD_CYC / 2);

  // Register indices; byte address is four times the index
  localparam logic [7:0] CPT_IDX_CTRL1 = 8'h01;
  localparam logic [7:0] CPT_IDX_CTRL2 = 8'h02;
  localparam logic [7:0] CPT_IDX_RX_ATT = 8'h14;
  localparam logic [7:0] CPT_IDX_TX_ATT = 8'h15;
  localparam logic [7:0] CPT_IDX_STATUS = 8'h16;

  // Field positions
  localparam int CPT_FMT_LSB = 4;
  localparam int CPT_TONE_EN_BIT = 3;
  localparam int CPT_IRQ_EN_BIT = 0;
  localparam int CPT_ST_PIN_BIT = 0;
  localparam int CPT_ST_ACTIVE_BIT = 1;
  localparam int CPT_ST_LEVEL_LSB = 16;

  // Reset values
  localparam logic [7:0] CPT_ATT_RST = 8'h00;
  localparam logic [1:0] CPT_FMT_RST = 2'h0;
  localparam logic CPT_TONE_EN_RST = 1'b0;
  localparam logic CPT_IRQ_EN_RST = 1'b0;

  // Attenuation is a fraction of 256
  localparam int CPT_ATT_SHIFT = 8;

  typedef enum logic [1:0] {
    CPT_FMT_DSIG = 2'h0,
    CPT_FMT_RZ = 2'h1,
    CPT_FMT_BAL = 2'h2,
    CPT_FMT_RSVD = 2'h3
  } cpt_fmt_e;

  typedef struct packed {
    logic signed [15:0] rx;
    logic signed [15:0] tx;
  } cpt_voice_s;

endpackage

// ==== hw/cpt_path_scaler.sv ====
// Linear scaler of one voice path for the monitor mix.
// Assumes a synchronous, already released active-low reset.
`timescale 1ns/1ps
module cpt_path_scaler (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic signed [15:0] i_sample,
  input wire logic [7:0] i_atten,
  output logic signed [23:0] o_scaled
);

  typedef struct packed {
    logic signed [23:0] prod;
  } cpt_scl_state_s;

  cpt_scl_state_s s_reg;
  cpt_scl_state_s s_next;

  always_comb begin
    s_next = s_reg;
    // Zero attenuation gives an exact zero product
    // Full-scale product needs 24 signed bits, so the cut loses nothing
    s_next.prod = 24'(i_sample * $signed({1'b0, i_atten})); // RULE2 RULE3
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_scaled = s_reg.prod;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  chk_scale_linear: assert property ( // RULE2
    ##1 o_scaled == 24'($past(i_sample) * $signed({1'b0, $past(i_atten)})))
    else $error("scaled sample not linear in attenuation");

  chk_zero_mutes: assert property ( // RULE3
    (i_atten == 8'h00) |=> (o_scaled == 24'sh000000))
    else $error("zero attenuation did not mute the path");

endmodule // cpt_path_scaler

// ==== hw/cpt_tone_mod.sv ====
// Tone pin modulator: delta-sigma, return-to-zero or balanced 32 kHz pulses.
// Assumes a synchronous, already released active-low reset.
`timescale 1ns/1ps
module cpt_tone_mod (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic signed [15:0] i_level,
  input wire cpt_pkg::cpt_fmt_e i_format,
  input wire logic i_enable,
  output logic o_pin
);

  typedef struct packed {
    logic [11:0] cnt;
    logic [11:0] thr;
    logic [15:0] acc;
    logic pin;
  } cpt_mod_state_s;

  cpt_mod_state_s s_reg;
  cpt_mod_state_s s_next;
  logic [15:0] ulevel;
  logic [27:0] duty;
  logic [16:0] dsum;
  logic [11:0] lo;
  logic [11:0] hi;

  // Offset binary so that silence is half duty
  assign ulevel = {~i_level[15], i_level[14:0]};
  assign duty = ulevel * cpt_pkg::CPT_PERIOD_W;
  assign dsum = {1'b0, s_reg.acc} + {1'b0, ulevel};
  assign lo = cpt_pkg::CPT_CNT_HALF - {1'b0, s_reg.thr[11:1]};
  assign hi = lo + s_reg.thr;

  always_comb begin
    s_next = s_reg;
    s_next.acc = dsum[15:0];
    if (s_reg.cnt == cpt_pkg::CPT_CNT_LAST) begin // RULE6
      s_next.cnt = 12'h000;
      // Duty only changes at a period edge to avoid runt pulses
      s_next.thr = duty[27:16];
    end else begin
      s_next.cnt = s_reg.cnt + 12'h001;
    end
    s_next.pin = 1'b0;
    if (i_enable) begin
      unique case (i_format) // RULE5 RULE7
        cpt_pkg::CPT_FMT_DSIG: s_next.pin = dsum[16]; // RULE6
        cpt_pkg::CPT_FMT_RZ: s_next.pin = (s_reg.cnt < s_reg.thr); // RULE6
        cpt_pkg::CPT_FMT_BAL: s_next.pin = (s_reg.cnt >= lo) && (s_reg.cnt < hi); // RULE6
        cpt_pkg::CPT_FMT_RSVD: s_next.pin = 1'b0; // RULE7
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_pin = s_reg.pin;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  chk_reserved_low: assert property ( // RULE7
    (i_format == cpt_pkg::CPT_FMT_RSVD) |=> !o_pin)
    else $error("reserved format drove the pin");

  chk_period_wrap: assert property ( // RULE6
    (s_reg.cnt == cpt_pkg::CPT_CNT_LAST) |=> (s_reg.cnt == 12'h000))
    else $error("tone period not 3125 cycles");

  chk_rz_returns: assert property ( // RULE6
    (i_enable && i_format == cpt_pkg::CPT_FMT_RZ && s_reg.cnt == cpt_pkg::CPT_CNT_LAST) |=> !o_pin)
    else $error("return-to-zero pulse did not return low");

  chk_bal_edges: assert property ( // RULE6
    // A full-scale level gives lo of zero: a pulse from count 0, one cycle short of the period
    (i_enable && i_format == cpt_pkg::CPT_FMT_BAL && s_reg.cnt == 12'h000 && lo != 12'h000) |=> !o_pin)
    else $error("balanced pulse high at period start");

  cov_rz_pulse: cover property (i_enable && i_format == cpt_pkg::CPT_FMT_RZ ##1 o_pin);
  cov_bal_pulse: cover property (i_enable && i_format == cpt_pkg::CPT_FMT_BAL ##1 o_pin);

endmodule // cpt_tone_mod

// ==== test/cpt_speaker_model.sv ====
// Speaker stage at the tone pin: counts driven cycles and pulse starts.
// Assumes the pin is sampled on the system clock; i_clear restarts counts.
`timescale 1ns/1ps
module cpt_speaker_model (
  input wire logic i_sys_clk,
  input wire logic i_clear,
  input wire logic i_drive,
  output logic [15:0] o_high_cnt,
  output logic [15:0] o_rise_cnt
);
  logic prev_reg = 1'b0;
  always_ff @(posedge i_sys_clk) begin
    prev_reg <= i_drive;
    if (i_clear) begin
      o_high_cnt <= 16'h0000;
      o_rise_cnt <= 16'h0000;
    end else begin
      // Transistor conducts only while the pin is high
      o_high_cnt <= o_high_cnt + 16'(i_drive);
      o_rise_cnt <= o_rise_cnt + 16'(i_drive & ~prev_reg);
    end
  end
endmodule // cpt_speaker_model

// ==== test/cpt_tone_out_tb.sv ====
// Self-checking bench of the tone output block over AHB-Lite.
// Assumes the speaker model at the pin and a 100 MHz clock.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end
module cpt_tone_out_tb;
  localparam int timeout_cyc = 90000;
  logic sys_clk, reset_n, hsel, hwrite, voice_valid, clear, hreadyout, hresp, line_valid, pin;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [15:0] high_cnt, rise_cnt;
  cpt_pkg::cpt_voice_s voice, line_voice;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  cpt_tone_out cpt_tone_out_inst (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout),
    .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp), .i_voice(voice), .i_voice_valid(voice_valid),
    .o_line_voice(line_voice), .o_line_valid(line_valid), .o_tone_output_pin(pin));
  cpt_speaker_model cpt_speaker_model_inst (.i_sys_clk(sys_clk), .i_clear(clear), .i_drive(pin),
    .o_high_cnt(high_cnt), .o_rise_cnt(rise_cnt));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == timeout_cyc) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= 32'(idx) << 2;
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus(1'b0, idx, 32'h0, d);
    `CHK(what, exp, d)
  endtask
  task automatic send_voice(input cpt_pkg::cpt_voice_s v);
    voice <= v;
    voice_valid <= 1'b1;
    @(posedge sys_clk);
    voice_valid <= 1'b0;
    @(posedge sys_clk);
    `CHK("line_valid", 1'b1, line_valid)
    `CHK("line_voice", v, line_voice)
  endtask
  task automatic measure(output logic [15:0] hi, output logic [15:0] rs);
    repeat (2 * cpt_pkg::CPT_PERIOD_CYC) @(posedge sys_clk);
    clear <= 1'b1;
    @(posedge sys_clk);
    clear <= 1'b0;
    repeat (cpt_pkg::CPT_PERIOD_CYC) @(posedge sys_clk);
    #1;
    hi = high_cnt;
    rs = rise_cnt;
  endtask
  task automatic test_regs();
    rd_chk(cpt_pkg::CPT_IDX_RX_ATT, 32'h0, "rx_att_reset");
    rd_chk(cpt_pkg::CPT_IDX_TX_ATT, 32'h0, "tx_att_reset");
    rd_chk(cpt_pkg::CPT_IDX_CTRL1, 32'h0, "ctrl1_reset");
    wr(cpt_pkg::CPT_IDX_RX_ATT, 32'hffffffff);
    rd_chk(cpt_pkg::CPT_IDX_RX_ATT, 32'h000000ff, "rx_att_width");
    wr(8'hff, 32'hffffffff);
    rd_chk(8'hff, 32'h0, "unmapped");
  endtask
  // Level seen in status after both gains and a fresh sample
  task automatic test_mix(input logic [15:0] rx, input logic [15:0] tx, input logic [7:0] ra, input logic [7:0] ta,
    input logic [15:0] exp);
    logic [31:0] d;
    wr(cpt_pkg::CPT_IDX_RX_ATT, 32'(ra));
    wr(cpt_pkg::CPT_IDX_TX_ATT, 32'(ta));
    send_voice({rx, tx});
    repeat (8) @(posedge sys_clk);
    bus(1'b0, cpt_pkg::CPT_IDX_STATUS, 32'h0, d);
    `CHK("mix_level", exp, d[31:16])
  endtask
  task automatic test_formats();
    logic [15:0] hi, rs;
    logic [31:0] d;
    // Level 0x1000 offsets to 0x9000
    logic [15:0] thr = 16'((32'h9000 * cpt_pkg::CPT_PERIOD_CYC) >> 16);
    for (int f = 0; f < 4; f++) begin
      wr(cpt_pkg::CPT_IDX_CTRL1, (32'(f) << cpt_pkg::CPT_FMT_LSB) | (32'h1 << cpt_pkg::CPT_TONE_EN_BIT));
      measure(hi, rs);
      bus(1'b0, cpt_pkg::CPT_IDX_STATUS, 32'h0, d);
      `CHK("active", (f != 3), d[cpt_pkg::CPT_ST_ACTIVE_BIT])
      if (f == 0) begin
        `CHK("dsig_duty", 1'b1, (hi >= thr - 16'd1 && hi <= thr + 16'd2))
        `CHK("dsig_stream", 1'b1, (rs > 16'd100))
      end else if (f == 3) begin
        `CHK("rsvd_high", 16'd0, hi)
      end else begin
        `CHK("pwm_high", thr, hi)
        `CHK("pwm_pulses", 16'd1, rs)
      end
    end
  endtask
  task automatic test_gating();
    logic [15:0] hi, rs;
    logic [31:0] d;
    wr(cpt_pkg::CPT_IDX_CTRL2, 32'h1);
    wr(cpt_pkg::CPT_IDX_CTRL1, 32'h18);
    measure(hi, rs);
    `CHK("irq_owns_pin", 16'd0, hi)
    wr(cpt_pkg::CPT_IDX_CTRL2, 32'h0);
    wr(cpt_pkg::CPT_IDX_CTRL1, 32'h10);
    measure(hi, rs);
    `CHK("tone_off", 16'd0, hi)
    wr(cpt_pkg::CPT_IDX_CTRL1, 32'h08);
    bus(1'b0, cpt_pkg::CPT_IDX_STATUS, 32'h0, d);
    `CHK("tone_on_active", 1'b1, d[cpt_pkg::CPT_ST_ACTIVE_BIT])
    `CHK("tone_on_level", 16'h1000, d[31:16])
  endtask
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    voice = '0;
    voice_valid = 1'b0;
    clear = 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    test_regs();
    test_mix(16'h1000, 16'h2000, 8'h00, 8'h00, 16'h0000);
    test_mix(16'h1000, 16'h2000, 8'h00, 8'h40, 16'h0800);
    test_mix(16'hf000, 16'h0000, 8'hff, 8'h00, 16'hf010);
    test_mix(16'h1000, 16'h2000, 8'h80, 8'h40, 16'h1000);
    test_formats();
    test_gating();
    stop_test();
  end
endmodule // cpt_tone_out_tb
